// ==== bench/csirx_ctrl_sva.sv ====
/* port checker for the camera receiver control block.
   assumes a bind onto csirx_ctrl and the single aclk domain. */
`timescale 1ns/1ps
module csirx_ctrl_sva (
    input wire logic       aclk,          // clock
    input wire logic       aresetn,       // reset, low
    input wire logic       s_axi_awvalid, // aw valid
    input wire logic       s_axi_awready, // aw ready
    input wire logic       s_axi_wvalid,  // w valid
    input wire logic       s_axi_wready,  // w ready
    input wire logic       s_axi_bvalid,  // b valid
    input wire logic       s_axi_arvalid, // ar valid
    input wire logic       s_axi_arready, // ar ready
    input wire logic       s_axi_rvalid,  // r valid
    input wire logic [3:0] frame_sync,    // frame active
    input wire logic       video_valid,   // video strobe
    input wire logic [2:0] video_count,   // bytes valid
    input wire logic [4:0] error_status,  // sticky events
    input wire logic       irq            // interrupt
);
    // write data taken this cycle
    wire w_taken = s_axi_wvalid && s_axi_wready;
    // ==========
    // one domain; reset mutes every check
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_irq_quiet: assert property (
        error_status == 5'h00 |-> !irq)
        else $error("irq high with no event pending");
    a_b_follows: assert property (
        $rose(s_axi_bvalid) |-> $past(w_taken) || $past(w_taken, 2))
        else $error("write response without write data");
    a_r_follows: assert property (
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read data not one cycle after address");
    a_ar_blocked: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open while data pending");
    a_aw_gap: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready not dropped");
    a_count_range: assert property (
        video_valid |-> video_count inside {[3'h1:3'h4]})
        else $error("video byte count out of range");
    a_fs_event: assert property (
        |(frame_sync & ~$past(frame_sync)) |-> ##[0:3] error_status[3])
        else $error("frame sync rose without frame start event");
    a_err_clear: assert property (
        |($past(error_status) & ~error_status) |->
        $past(w_taken) || $past(w_taken, 2) || $past(w_taken, 3))
        else $error("event bit dropped without a write");
endmodule // csirx_ctrl_sva

// ==== bench/csirx_ctrl_test.sv ====
/* self-checking bench: axi4-lite master, link source, result queues.
   assumes csirx_consts.vh on the include path and a 250 MHz aclk. */
`timescale 1ns/1ps
`include "csirx_consts.vh"
module csirx_ctrl_test;
    localparam logic [7:0] CT = `CSIRX_OFS_CTRL, ST = `CSIRX_OFS_STATUS;
    localparam logic [7:0] EV = `CSIRX_OFS_EVENT, MK = `CSIRX_OFS_MASK;
    localparam logic [1:0] OK = `CSIRX_RESP_OKAY;
    logic        aclk = 1'h0, cal_clk = 1'h0, aresetn = 1'h0;
    logic        phy_layer_reset_n = 1'h1;
    logic        protocol_controller_reset_n = 1'h1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, base;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, video_data, vmask, dat;
    logic [3:0]  s_axi_wstrb = 4'hF, frame_sync, line_sync, link_data_lane;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, video_valid;
    logic        irq, link_clk_lane;
    logic [1:0]  s_axi_bresp, s_axi_rresp, video_vc, vc, exp_b[$];
    logic [1:0]  ln [3] = '{2'h0, 2'h1, 2'h3};
    logic [2:0]  video_count;
    logic [5:0]  video_type;
    logic [4:0]  error_status;
    logic [15:0] wc;
    logic [65:0] exp_r[$], er;   // resp, mask, value
    logic [42:0] exp_v[$];       // count, channel, type, data
    int          bad_count = 0, samples_checked = 0, seed = 4, n, cnt;
    csirx_ctrl dut (.*); // every control input driven
    csirx_link_src link (.link_clk_lane, .link_data_lane);
    // ==========
    // clocks; calibration clock at 100 MHz
    always #2 aclk = ~aclk;
    always #5 cal_clk = ~cal_clk;
    assign vmask = 32'hFFFF_FFFF >> (6'h20 - {video_count, 3'h0});
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic summarize;
        if (bad_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watcher: each answer against the oldest note
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            check(s_axi_bresp, exp_b.pop_front());
        if (s_axi_rvalid && s_axi_rready) begin
            er = exp_r.pop_front();
            check({s_axi_rresp, s_axi_rdata & er[63:32]},
                  {er[65:64], er[31:0]});
        end
        if (video_valid && exp_v.size() == 0)
            check(1'h1, 1'h0);
        else if (video_valid)
            check({video_count, video_vc, video_type, video_data & vmask},
                  exp_v.pop_front());
    end
    // ==========
    // bus master: valid held until taken, ready held until answered
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        bit ad = 0, wd = 0;
        exp_b.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready && !ad) s_axi_awvalid <= 1'h0;
            if (s_axi_wready && !wd) s_axi_wvalid <= 1'h0;
            ad |= s_axi_awready;
            wd |= s_axi_wready;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v, input logic [1:0] r);
        exp_r.push_back({r, m, v});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
    endtask
    // both reset pins pulsed together, never one alone
    task automatic pins;
        phy_layer_reset_n <= 1'h0;
        protocol_controller_reset_n <= 1'h0;
        repeat (8) @(posedge aclk);
        rd(ST, 32'h1800, 32'h1800, OK);
        phy_layer_reset_n <= 1'h1;
        protocol_controller_reset_n <= 1'h1;
        repeat (10) @(posedge aclk);
    endtask
    // ==========
    // main sequence: lane codes 00, 01 and 11, then refused traffic
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        rd(CT, '1, `CSIRX_CTRL_RESET, OK);
        rd(8'h18, '1, 32'h0, `CSIRX_RESP_SLVERR);
        wr(8'h1C, 32'h1, `CSIRX_RESP_SLVERR);
        wr(MK, 32'h18, OK);
        foreach (ln[i]) begin
            vc = 2'($random(seed));
            wc = 16'h1 + 16'($random(seed) & 7);
            base = 8'($random(seed));
            n = (ln[i] == 2'h3) ? 4 : ln[i] + 1;
            wr(CT, 32'hF0 | ln[i], OK); // latched by the reset
            pins();
            rd(ST, 32'h1FFF, {ln[i], 8'h00}, OK);
            link.send(ln[i], {vc, `CSIRX_DT_FS}, 16'h0, 8'h0);
            link.send(ln[i], {vc, `CSIRX_DT_LS}, 16'h0, 8'h0);
            repeat (40) @(posedge aclk);
            rd(ST, 32'hFF, 32'h11 << vc, OK);
            check({line_sync, frame_sync}, 32'h11 << vc);
            for (int k = 0; k < wc; k += n) begin
                cnt = (wc - k < n) ? wc - k : n;
                dat = 32'h0;
                for (int j = 0; j < cnt; j++) dat[8*j +: 8] = base + 8'(k + j);
                exp_v.push_back({3'(cnt), vc, 6'h2A, dat});
            end
            link.send(ln[i], {vc, 6'h2A}, wc, base);
            link.send(ln[i], {vc, `CSIRX_DT_LE}, 16'h0, 8'h0);
            link.send(ln[i], {vc, `CSIRX_DT_FE}, 16'h0, 8'h0);
            repeat (40) @(posedge aclk);
            rd(ST, 32'hFF, 32'h0, OK);
            check({line_sync, frame_sync}, 8'h00);
            rd(EV, 32'h1F, 32'h18, OK);
            check(error_status, 5'h18);
            check(irq, 1'h1);
            wr(EV, 32'h10, OK);
            rd(EV, 32'h1F, 32'h08, OK);
            wr(`CSIRX_OFS_CLEAR, 32'h1, OK);
            rd(EV, 32'h1F, 32'h00, OK);
            check(error_status, 5'h00);
            check(irq, 1'h0);
        end
        wr(CT, 32'hB3, OK); // channel 2 off
        wr(MK, 32'h00, OK);
        link.send(2'h3, {2'h2, `CSIRX_DT_FS}, 16'h0, 8'h0);
        link.send(2'h3, {2'h0, 6'h2A}, 16'h0, 8'h0);
        link.send(2'h3, {2'h1, `CSIRX_DT_FE}, 16'h0, 8'h0);
        repeat (40) @(posedge aclk);
        rd(ST, 32'hF, 32'h0, OK);
        rd(EV, 32'h7, 32'h7, OK);
        check(error_status, 5'h17);
        check(irq, 1'h0);
        wr(MK, 32'h02, OK);
        rd(MK, 32'h1F, 32'h02, OK);
        check(irq, 1'h1);
        rd(`CSIRX_OFS_LASTHDR, '1, 32'h41, OK);
        summarize();
    end
    // watchdog: the run needs under 100 us of link time
    initial begin
        #300us;
        bad_count++;
        summarize();
    end
endmodule // csirx_ctrl_test
bind csirx_ctrl csirx_ctrl_sva chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .frame_sync,
    .video_valid, .video_count, .error_status, .irq);

// ==== bench/csirx_link_src.sv ====
/* far-side camera source: one packet per call on four data lanes.
   assumes the receiver samples lanes on the rising link clock. */
`timescale 1ns/1ps
module csirx_link_src (
    output logic       link_clk_lane, // stands low between packets
    output logic [3:0] link_data_lane // lane levels
);
    logic [31:0] w = 32'h5A5A_5A5A;
    // ==========
    // idle levels
    initial begin
        link_clk_lane = 1'h0;
        link_data_lane = 4'h0;
    end
    // one byte-time, lsb first, 125 ns link period
    task automatic put(input logic [31:0] v);
        for (int b = 0; b < 8; b++) begin
            link_data_lane = {v[24+b], v[16+b], v[8+b], v[b]};
            #62.5 link_clk_lane = 1'h1;
            #62.5 link_clk_lane = 1'h0;
        end
    endtask
    // sync, header, payload, trailer; unused lanes carry junk
    task automatic send(input logic [1:0] code, input logic [7:0] di,
                        input logic [15:0] wc, input logic [7:0] base);
        logic [7:0] q[$];
        int         n;
        #1; // step off the aclk edge before touching the lanes
        n = (code == 2'h3) ? 4 : code + 1; // code 10 never sent
        q = {di, wc[7:0], wc[15:8], 8'h00}; // ecc left zero
        if (di[5:0] >= 6'h10)
            for (int k = 0; k < wc; k++) q.push_back(base + 8'(k));
        put(32'hB8B8_B8B8);
        while (q.size() > 0) begin
            w = ~w;
            for (int i = 0; i < n; i++)
                if (q.size() > 0) w[8*i +: 8] = q.pop_front();
            put(w);
        end
        put(32'h0000_0000);
        link_data_lane = ~link_data_lane; // released, not left at last
    endtask
endmodule // csirx_link_src

// ==== core/csirx_consts.vh ====
/*
 * Constants for the camera receiver control block: register offsets,
 * field positions, reset values, packet codes and axi responses.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef CSIRX_CONSTS_VH
`define CSIRX_CONSTS_VH

// =========================================================
// register byte offsets (axi4-lite, one word each)
`define CSIRX_OFS_CTRL      8'h00
`define CSIRX_OFS_STATUS    8'h04
`define CSIRX_OFS_EVENT     8'h08
`define CSIRX_OFS_MASK      8'h0C
`define CSIRX_OFS_CLEAR     8'h10
`define CSIRX_OFS_LASTHDR   8'h14

// =========================================================
// field positions
`define CSIRX_CTRL_LANES_LSB 0
`define CSIRX_CTRL_CHEN_LSB  4
`define CSIRX_CTRL_RESET     32'h0000_00F0
`define CSIRX_EV_FS_ERR      0
`define CSIRX_EV_BAD_VC      1
`define CSIRX_EV_BAD_LEN     2
`define CSIRX_EV_FRAME_START 3
`define CSIRX_EV_FRAME_END   4
`define CSIRX_EV_W           5

// =========================================================
// lane selector codes, link codes
`define CSIRX_LANES_1        2'h0
`define CSIRX_LANES_2        2'h1
`define CSIRX_LANES_4        2'h3
`define CSIRX_SYNC_BYTE      8'hB8
`define CSIRX_DT_FS          6'h00
`define CSIRX_DT_FE          6'h01
`define CSIRX_DT_LS          6'h02
`define CSIRX_DT_LE          6'h03
`define CSIRX_DT_LONG_MIN    6'h10

// =========================================================
// axi responses
`define CSIRX_RESP_OKAY      2'h0
`define CSIRX_RESP_SLVERR    2'h2

`endif

// ==== core/csirx_ctrl.v ====
/*
 * Camera receiver control block: samples one clock lane and four data
 * lanes, aligns bytes, decodes short and long packets per virtual
 * channel, drives frame sync, video and error reporting, and exposes
 * control and status over an axi4-lite slave.
 * Assumes lane pins are already resolved to single-ended levels, that
 * the link clock is much slower than aclk, and that aclk is the pixel
 * transfer clock supplied by the core.
 */
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "csirx_consts.vh"

module csirx_ctrl (
    input  wire        aclk,                 // pixel transfer clock
    input  wire        aresetn,              // sync reset, active low
    input  wire        cal_clk,              // calibration clock, unused
    input  wire        phy_layer_reset_n,    // phy reset pin, active low
    input  wire        protocol_controller_reset_n, // ctrl reset pin
    input  wire        link_clk_lane,        // clock lane level
    input  wire [3:0]  link_data_lane,       // data lane levels
    input  wire [7:0]  s_axi_awaddr,         // write address
    input  wire        s_axi_awvalid,        // write address valid
    output reg         s_axi_awready,        // write address ready
    input  wire [31:0] s_axi_wdata,          // write data
    input  wire [3:0]  s_axi_wstrb,          // write strobes
    input  wire        s_axi_wvalid,         // write data valid
    output reg         s_axi_wready,         // write data ready
    output reg  [1:0]  s_axi_bresp,          // write response
    output reg         s_axi_bvalid,         // write response valid
    input  wire        s_axi_bready,         // write response ready
    input  wire [7:0]  s_axi_araddr,         // read address
    input  wire        s_axi_arvalid,        // read address valid
    output reg         s_axi_arready,        // read address ready
    output reg  [31:0] s_axi_rdata,          // read data
    output reg  [1:0]  s_axi_rresp,          // read response
    output reg         s_axi_rvalid,         // read data valid
    input  wire        s_axi_rready,         // read data ready
    output reg  [3:0]  frame_sync,           // frame active per channel
    output reg  [3:0]  line_sync,            // line active per channel
    output reg         video_valid,          // video word strobe
    output reg  [31:0] video_data,           // payload bytes, lane order
    output reg  [2:0]  video_count,          // valid bytes in video_data
    output reg  [5:0]  video_type,           // packet data type
    output reg  [1:0]  video_vc,             // packet virtual channel
    output reg  [4:0]  error_status,         // sticky error/event bits
    output reg         irq                   // level interrupt
);

// =========================================================
// pin synchronisers: three flops, change taken when 2nd and 3rd agree
localparam SW = 7;
reg  [SW-1:0] s1, s2, s3, pin_q;
wire [SW-1:0] pins = {protocol_controller_reset_n, phy_layer_reset_n,
                      link_data_lane, link_clk_lane};

always @(posedge aclk) begin
    s1 <= pins;
    s2 <= s1;
    s3 <= s2;
    if (!aresetn)
        pin_q <= 7'h60; // resets released, lanes low
    else
        pin_q <= (pin_q & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
end

wire       lclk_rise = pin_q[0] == 1'b0 && (s2[0] & s3[0]);
wire [3:0] lane_bit  = pin_q[4:1];
wire       phy_rst   = !aresetn || !pin_q[5];
wire       ctl_rst   = !aresetn || !pin_q[6];

// =========================================================
// control register; lane count latched from it only while in reset
reg  [31:0] ctrl;
reg  [4:0]  ev_mask;
reg  [1:0]  lanes_q;
reg  [2:0]  nl;                       // active data lanes 1, 2 or 4
wire [3:0]  ch_en = ctrl[`CSIRX_CTRL_CHEN_LSB +: 4];

always @(posedge aclk) begin
    if (!aresetn)
        lanes_q <= `CSIRX_LANES_1;
    else if (ctl_rst)
        lanes_q <= ctrl[`CSIRX_CTRL_LANES_LSB +: 2];
end

// reserved code 10 decodes as four lanes
always @* begin
    case (lanes_q)
        `CSIRX_LANES_1: nl = 3'd1;
        `CSIRX_LANES_2: nl = 3'd2;
        default:        nl = 3'd4;
    endcase
end

// =========================================================
// deserializer: lsb-first shift per lane, aligned by sync byte on lane 0
reg  [7:0] sh0, sh1, sh2, sh3;
reg  [2:0] bitcnt;
reg        aligned;
reg        byte_rdy;
reg        rx_done;                   // packet consumed, hunt again
wire [7:0] nsh0 = {lane_bit[0], sh0[7:1]};

always @(posedge aclk) begin
    byte_rdy <= 1'b0;
    if (phy_rst || rx_done) begin
        aligned <= 1'b0;
        bitcnt  <= 3'd0;
        sh0 <= 8'h00; sh1 <= 8'h00; sh2 <= 8'h00; sh3 <= 8'h00;
    end else if (lclk_rise) begin
        sh0 <= nsh0;
        sh1 <= {lane_bit[1], sh1[7:1]};
        sh2 <= {lane_bit[2], sh2[7:1]};
        sh3 <= {lane_bit[3], sh3[7:1]};
        if (!aligned) begin
            aligned <= nsh0 == `CSIRX_SYNC_BYTE;
            bitcnt  <= 3'd0;
        end else begin
            bitcnt   <= bitcnt + 3'd1;
            byte_rdy <= bitcnt == 3'd7;
        end
    end
end

// =========================================================
// packet decoder states
localparam ST_HDR = 3'b001;
localparam ST_PAY = 3'b010;
localparam ST_END = 3'b100;
reg  [2:0]  state;
reg  [31:0] hdr;
reg  [2:0]  hidx;
reg  [15:0] remain;
reg         drop;
reg  [31:0] next_hdr;
reg  [4:0]  ev;
wire [31:0] lane_bytes = {sh3, sh2, sh1, sh0};
wire [1:0]  h_vc = next_hdr[7:6];
wire [5:0]  h_dt = next_hdr[5:0];
wire [15:0] h_wc = next_hdr[23:8];
wire [15:0] nl16 = {13'h0000, nl};
integer k;

// gather header bytes in lane order across byte times
always @* begin
    next_hdr = hdr;
    for (k = 0; k < 4; k = k + 1)
        if (k < nl && hidx + k < 4)
            next_hdr[8*(hidx+k) +: 8] = lane_bytes[8*k +: 8];
end

always @(posedge aclk) begin
    ev          <= 5'h00;
    rx_done     <= 1'b0;
    video_valid <= 1'b0;
    if (ctl_rst) begin
        state <= ST_HDR; hdr <= 32'h0; hidx <= 3'd0; remain <= 16'h0;
        drop <= 1'b0; frame_sync <= 4'h0; line_sync <= 4'h0;
        video_data <= 32'h0; video_count <= 3'd0;
        video_type <= 6'h00; video_vc <= 2'h0;
    end else if (!aligned) begin
        state <= ST_HDR;
        hidx  <= 3'd0;
    end else if (byte_rdy) begin
        case (state)
            ST_HDR: begin
                hdr <= next_hdr;
                if ({1'b0, hidx} + {1'b0, nl} < 4'd4)
                    hidx <= hidx + nl;
                else if (!ch_en[h_vc]) begin
                    ev[`CSIRX_EV_BAD_VC] <= 1'b1;
                    drop   <= 1'b1;
                    remain <= h_wc;
                    state  <= h_dt >= `CSIRX_DT_LONG_MIN ? ST_PAY : ST_END;
                end else if (h_dt >= `CSIRX_DT_LONG_MIN) begin
                    drop       <= 1'b0;
                    remain     <= h_wc;
                    video_type <= h_dt;
                    video_vc   <= h_vc;
                    ev[`CSIRX_EV_BAD_LEN] <= h_wc == 16'h0000;
                    state <= h_wc == 16'h0000 ? ST_END : ST_PAY;
                end else begin
                    state <= ST_END;
                    case (h_dt)
                        `CSIRX_DT_FS: begin
                            frame_sync[h_vc] <= 1'b1;
                            ev[`CSIRX_EV_FRAME_START] <= 1'b1;
                        end
                        `CSIRX_DT_FE: begin
                            frame_sync[h_vc] <= 1'b0;
                            ev[`CSIRX_EV_FRAME_END] <= 1'b1;
                            ev[`CSIRX_EV_FS_ERR] <= !frame_sync[h_vc];
                        end
                        `CSIRX_DT_LS: line_sync[h_vc] <= 1'b1;
                        `CSIRX_DT_LE: line_sync[h_vc] <= 1'b0;
                        default: ;
                    endcase
                end
            end
            // payload bytes leave as they arrive, trailing crc ignored
            ST_PAY: begin
                video_valid <= !drop;
                video_data  <= lane_bytes;
                video_count <= remain < nl16 ? remain[2:0] : nl;
                if (remain <= nl16) begin
                    remain <= 16'h0000;
                    state  <= ST_END;
                end else
                    remain <= remain - nl16;
            end
            // one packet per burst: drop alignment and hunt again
            ST_END: begin
                rx_done <= 1'b1;
                hidx    <= 3'd0;
                state   <= ST_HDR;
            end
            default: state <= ST_HDR;
        endcase
    end
end

// =========================================================
// axi4-lite write channel: address and data taken in either order
reg  [7:0]  wr_addr;
reg  [31:0] wr_data;
reg  [3:0]  wr_strb;
reg         aw_have, w_have;
wire        aw_hs   = s_axi_awvalid && s_axi_awready;
wire        w_hs    = s_axi_wvalid && s_axi_wready;
wire        wr_fire = aw_have && w_have && !s_axi_bvalid;
wire        next_aw_have = (aw_have || aw_hs) && !wr_fire;
wire        next_w_have  = (w_have || w_hs) && !wr_fire;
wire        wr_ctrl  = wr_fire && wr_addr == `CSIRX_OFS_CTRL;
wire        wr_mask  = wr_fire && wr_addr == `CSIRX_OFS_MASK;
wire        wr_event = wr_fire && wr_addr == `CSIRX_OFS_EVENT;
wire        wr_clear = wr_fire && wr_addr == `CSIRX_OFS_CLEAR;
wire        wr_ok = wr_ctrl || wr_mask || wr_event || wr_clear ||
                    wr_addr == `CSIRX_OFS_STATUS ||
                    wr_addr == `CSIRX_OFS_LASTHDR;
integer b;

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_have <= 1'b0; w_have <= 1'b0;
        s_axi_awready <= 1'b0; s_axi_wready <= 1'b0;
        s_axi_bvalid  <= 1'b0; s_axi_bresp  <= `CSIRX_RESP_OKAY;
        wr_addr <= 8'h00; wr_data <= 32'h0; wr_strb <= 4'h0;
        ctrl    <= `CSIRX_CTRL_RESET;
        ev_mask <= 5'h00;
    end else begin
        aw_have <= next_aw_have;
        w_have  <= next_w_have;
        s_axi_awready <= !next_aw_have;
        s_axi_wready  <= !next_w_have;
        if (aw_hs)
            wr_addr <= {s_axi_awaddr[7:2], 2'b00};
        if (w_hs) begin
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
        if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `CSIRX_RESP_OKAY : `CSIRX_RESP_SLVERR;
        end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
        for (b = 0; b < 4; b = b + 1)
            if (wr_ctrl && wr_strb[b])
                ctrl[8*b +: 8] <= wr_data[8*b +: 8];
        if (wr_mask && wr_strb[0])
            ev_mask <= wr_data[4:0];
    end
end

// =========================================================
// sticky events: hardware set wins over event-register or clear-register clear
wire [4:0] ev_clr = (wr_event && wr_strb[0] ? wr_data[4:0] : 5'h00) |
                    (wr_clear && wr_strb[0] && wr_data[0] ? 5'h1F : 5'h00);

always @(posedge aclk) begin
    if (!aresetn) begin
        error_status <= 5'h00;
        irq          <= 1'b0;
    end else begin
        error_status <= (error_status & ~ev_clr) | ev;
        irq <= |(((error_status & ~ev_clr) | ev) & ev_mask);
    end
end

// =========================================================
// axi4-lite read channel: answer one cycle after the address is taken
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0;
        s_axi_rresp   <= `CSIRX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `CSIRX_RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'b00})
            `CSIRX_OFS_CTRL:    s_axi_rdata <= ctrl & 32'h0000_00F3;
            `CSIRX_OFS_STATUS:  s_axi_rdata <= {19'h0, !pin_q[6],
                                    !pin_q[5], aligned, lanes_q,
                                    line_sync, frame_sync};
            `CSIRX_OFS_EVENT:   s_axi_rdata <= {27'h0, error_status};
            `CSIRX_OFS_MASK:    s_axi_rdata <= {27'h0, ev_mask};
            `CSIRX_OFS_CLEAR:   s_axi_rdata <= 32'h0;
            `CSIRX_OFS_LASTHDR: s_axi_rdata <= hdr;
            default: begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= `CSIRX_RESP_SLVERR;
            end
        endcase
    end else begin
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end
end

endmodule // csirx_ctrl
